// ---- muxed_bus_pkg.sv ----
// shared types and constants for the multiplexed byte bus port
package muxed_bus_pkg;
    // =========================================================
    // widths and reset values
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 8;
    localparam logic [7:0]  RST_ADDR   = 8'h00;
    localparam logic [7:0]  RST_DATA   = 8'h00;
    localparam logic        RST_MODE   = 1'b0;  // enable style, pulldown default

    // =========================================================
    // bus styles
    typedef enum logic { STYLE_ENABLE, STYLE_STROBE } bus_style_e;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [7:0] data;   // level sampled on the shared lines
        logic       addr_stb;
        logic       data_stb;
        logic       dir_wr;
        logic       unit_sel_n;
    } pin_in_s;

    typedef struct packed {
        logic       rd;     // one-cycle read request
        logic       wr;     // one-cycle write request
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_s;
endpackage : muxed_bus_pkg

// ---- strobe_edge.sv ----
// registered edge detector for one synchronous strobe input
`timescale 1ns/100ps
module strobe_edge (
    input  wire logic clk_sys_i,   // system clock
    input  wire logic reset_n_i,   // async reset, active low
    input  wire logic level_i,     // sampled strobe level
    input  wire logic rst_level_i, // idle level of the strobe
    output logic      prev_o,      // level one cycle earlier
    output logic      rise_o,      // pulse on low to high
    output logic      fall_o       // pulse on high to low
);
    // =========================================================
    // state
    logic prev_ff;
    logic nxt_prev;
    logic seen_ff;
    logic nxt_seen;

    always_comb begin
        nxt_prev = level_i;
        nxt_seen = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            seen_ff <= nxt_seen;
        end
    end

    // first cycle after reset compares against the idle level
    assign prev_o = seen_ff ? prev_ff : rst_level_i;
    assign rise_o = level_i & ~prev_o;
    assign fall_o = ~level_i & prev_o;
endmodule : strobe_edge

// ---- muxed_byte_bus_interface.sv ----
// multiplexed address/data byte bus port with strobe and enable styles
//
// How it works
// RULE_01 - access only while unit select is low
// RULE_02 - host holds select across strobes
// RULE_03 - deselected cycle latches address, no access
// RULE_04 - power fail forces select inactive
// RULE_05 - address captured at address strobe fall
// RULE_06 - address strobe rise discards latched address
// RULE_07 - host strobes address before every access
// RULE_08 - host re-strobes address after deselected attempt
// RULE_09 - style pin sets meaning of strobes
// RULE_10 - strobe style: direction high means read
// RULE_11 - strobe style: direction low means write
// RULE_12 - enable style: write latched at enable rise
// RULE_13 - host pulses data strobe after address phase
// RULE_14 - strobe style: drive only while strobe high
// RULE_15 - strobe style: write at strobe falling edge
// RULE_16 - enable style: drive only while strobe low
// RULE_17 - style high strobe, low enable default
// RULE_18 - read ends and bus floats on edge
// RULE_19 - reset pin low refuses all accesses
// RULE_20 - host never asserts both enables together
`timescale 1ns/100ps
module muxed_byte_bus_interface
    import muxed_bus_pkg::*;
(
    input  wire logic              clk_sys_i,        // 25 MHz system clock
    input  wire logic              reset_n_i,        // async reset, active low
    input  wire logic [DATA_W-1:0] bus_lines_i,      // shared lines, input side
    output logic      [DATA_W-1:0] bus_lines_o,      // shared lines, output side
    output logic                   bus_lines_oe_n_o, // low while driving lines
    input  wire logic              addr_latch_strobe_i, // address strobe, high pulse
    input  wire logic              data_strobe_line_i,  // data strobe or read enable
    input  wire logic              dir_write_line_i,    // direction or write enable
    input  wire logic              unit_select_n_i,     // chip select, active low
    input  wire logic              bus_style_select_i,  // high strobe, low enable
    input  wire logic              power_fail_i,        // supply below threshold
    input  wire logic              host_reset_n_i,      // reset pin, active low
    output core_req_s              core_req_o,          // request to storage core
    input  wire logic [DATA_W-1:0] core_rdata_i         // read data for core_req_o.addr
);
    // =========================================================
    // sampled pins and edges
    pin_in_s    pin;
    logic       as_prev, as_rise, as_fall;
    logic       ds_prev, ds_rise, ds_fall;
    logic       rw_prev, rw_rise, rw_fall;
    logic       sel_act;
    bus_style_e mode;

    always_comb begin
        pin.data       = bus_lines_i;
        pin.addr_stb   = addr_latch_strobe_i;
        pin.data_stb   = data_strobe_line_i;
        pin.dir_wr     = dir_write_line_i;
        pin.unit_sel_n = unit_select_n_i;
    end

    strobe_edge u_as_edge (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .level_i     (pin.addr_stb),
        .rst_level_i (1'b0),
        .prev_o      (as_prev),
        .rise_o      (as_rise),
        .fall_o      (as_fall)
    );

    strobe_edge u_ds_edge (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .level_i     (pin.data_stb),
        .rst_level_i (1'b0),
        .prev_o      (ds_prev),
        .rise_o      (ds_rise),
        .fall_o      (ds_fall)
    );

    strobe_edge u_rw_edge (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .level_i     (pin.dir_wr),
        .rst_level_i (1'b1),
        .prev_o      (rw_prev),
        .rise_o      (rw_rise),
        .fall_o      (rw_fall)
    );

    // =========================================================
    // select gating and style
    logic mode_ff;
    logic nxt_mode;

    assign sel_act = ~pin.unit_sel_n & ~power_fail_i & host_reset_n_i; // RULE_01 RULE_04 RULE_19
    assign mode    = bus_style_e'(mode_ff);

    always_comb begin
        nxt_mode = bus_style_select_i; // RULE_09 RULE_17
    end

    // =========================================================
    // address phase
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic              addr_vld_ff;
    logic              nxt_addr_vld;
    logic              data_done;

    always_comb begin
        nxt_addr     = addr_ff;
        nxt_addr_vld = addr_vld_ff;
        if (data_done) begin
            nxt_addr_vld = 1'b0;
        end
        if (as_rise) begin
            nxt_addr_vld = 1'b0;          // RULE_06
        end else if (as_fall) begin
            nxt_addr     = pin.data;      // RULE_05 RULE_03
            nxt_addr_vld = 1'b1;
        end
    end

    // =========================================================
    // data phase
    logic              rd_win;
    logic              wr_hit;
    logic              wr_stage;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic              drive_ff;
    logic              nxt_drive;
    core_req_s         req_ff;
    core_req_s         nxt_req;

    always_comb begin
        if (mode == STYLE_STROBE) begin
            rd_win    = pin.data_stb & pin.dir_wr;                  // RULE_10 RULE_14
            wr_stage  = pin.data_stb & ~pin.dir_wr;
            wr_hit    = ds_fall & ~rw_prev;                         // RULE_11 RULE_15
            data_done = ds_fall;
        end else begin
            rd_win    = ~pin.data_stb & pin.dir_wr;                 // RULE_16
            wr_stage  = ~pin.dir_wr;
            wr_hit    = rw_rise;                                    // RULE_12
            data_done = rw_rise | ds_rise;
        end
        rd_win = rd_win & sel_act & addr_vld_ff & ~pin.addr_stb;
        wr_hit = wr_hit & sel_act & addr_vld_ff;                    // RULE_03
    end

    always_comb begin
        nxt_wdata     = wr_stage ? pin.data : wdata_ff;
        nxt_drive     = rd_win;                                     // RULE_18
        nxt_rdata     = (rd_win & ~drive_ff) ? core_rdata_i : rdata_ff;
        nxt_req.rd    = rd_win & ~drive_ff;
        nxt_req.wr    = wr_hit;
        nxt_req.addr  = addr_ff;
        nxt_req.wdata = wdata_ff;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_ff     <= RST_MODE;
            addr_ff     <= RST_ADDR;
            addr_vld_ff <= 1'b0;
            wdata_ff    <= RST_DATA;
            rdata_ff    <= RST_DATA;
            drive_ff    <= 1'b0;
            req_ff      <= '0;
        end else begin
            mode_ff     <= nxt_mode;
            addr_ff     <= nxt_addr;
            addr_vld_ff <= nxt_addr_vld;
            wdata_ff    <= nxt_wdata;
            rdata_ff    <= nxt_rdata;
            drive_ff    <= nxt_drive;
            req_ff      <= nxt_req;
        end
    end

    // address stays on the request while a read is open so the core keeps it
    always_comb begin
        core_req_o      = req_ff;
        core_req_o.addr = addr_ff;
    end
    assign bus_lines_o      = rdata_ff;
    assign bus_lines_oe_n_o = ~drive_ff;

    // =========================================================
    // checks
    sequence s_strobe_fall;
        mode_ff && ds_fall;
    endsequence

    sequence s_enable_wr_rise;
        !mode_ff && rw_rise && sel_act && addr_vld_ff;
    endsequence

    a_addr_capture: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_05
        as_fall |=> addr_vld_ff && addr_ff == $past(bus_lines_i))
        else $error("address not captured at strobe fall");

    a_addr_discard: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_06
        as_rise |=> !addr_vld_ff ##1 (!core_req_o.wr && !core_req_o.rd))
        else $error("address kept after strobe rise");

    a_select_gates: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_01
        (core_req_o.wr || core_req_o.rd) |-> $past(!unit_select_n_i))
        else $error("access without unit select");

    a_power_fail_block: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_04
        power_fail_i |=> !core_req_o.wr && !core_req_o.rd && bus_lines_oe_n_o)
        else $error("access during power fail");

    a_pin_reset_block: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_19
        !host_reset_n_i [*2] |-> bus_lines_oe_n_o && !core_req_o.wr)
        else $error("access while reset pin low");

    a_strobe_drive: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_14
        (!bus_lines_oe_n_o && $past(mode_ff)) |-> $past(data_strobe_line_i && dir_write_line_i))
        else $error("strobe style drive outside read window");

    a_enable_drive: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_16
        (!bus_lines_oe_n_o && !$past(mode_ff)) |-> $past(!data_strobe_line_i))
        else $error("enable style drive with enable high");

    a_strobe_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_15
        (s_strobe_fall ##0 (!rw_prev && sel_act && addr_vld_ff))
        |=> core_req_o.wr && core_req_o.wdata == $past(wdata_ff))
        else $error("strobe style write not issued at strobe fall");

    a_enable_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_12
        s_enable_wr_rise |=> core_req_o.wr ##1 !core_req_o.wr)
        else $error("enable style write not issued at enable rise");

    a_read_end: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RULE_18
        s_strobe_fall |=> bus_lines_oe_n_o)
        else $error("bus still driven after strobe fall");
endmodule : muxed_byte_bus_interface

// ---- host_bus_model.sv ----
// host processor model driving the multiplexed byte bus
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic       clk_i,      // system clock
    input  wire logic       style_i,    // 1 strobe style, 0 enable style
    input  wire logic       dev_oe_n_i, // device drives lines when low
    input  wire logic [7:0] dev_data_i, // device read data
    output logic            as_o,       // address strobe
    output logic            ds_o,       // data strobe or read enable
    output logic            rw_o,       // direction or write enable
    output logic            cs_n_o,     // chip select, active low
    output logic [7:0]      data_o,     // host data on lines
    output logic            drive_n_o   // low while host drives lines
);
    initial begin
        as_o = 1'b0;
        ds_o = 1'b0;
        rw_o = 1'b1;
        cs_n_o = 1'b1;
        data_o = 8'h00;
        drive_n_o = 1'b1;
    end

    // ==========================================================
    // bus cycle helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic idle();
        ds_o = ~style_i;
        rw_o = 1'b1;
        cs_n_o = 1'b1;
        drive_n_o = 1'b1;
    endtask : idle

    task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] d,
                          input logic sel_n, input logic new_addr,
                          output logic seen, output logic [7:0] got);
        int lim;
        seen = 1'b0;
        got = 8'h00;
        lim = wr ? 2 : 8;
        step(1);
        cs_n_o = sel_n;
        if (new_addr) begin
            as_o = 1'b1;
            data_o = a;
            drive_n_o = 1'b0;
            step(2);
            as_o = 1'b0;
            step(1);
            drive_n_o = 1'b1;
        end
        if (wr) begin
            data_o = d;
            drive_n_o = 1'b0;
            rw_o = 1'b0;
        end else if (!style_i) begin
            ds_o = 1'b0;
        end
        if (style_i) begin
            step(1);
            ds_o = 1'b1;
        end
        for (int i = 0; i < lim && !seen; i++) begin
            step(1);
            if (!wr && dev_oe_n_i === 1'b0) begin
                seen = 1'b1;
                got = dev_data_i;
            end
        end
        if (style_i) ds_o = 1'b0;
        else if (wr) rw_o = 1'b1;
        else ds_o = 1'b1;
        step(2);
        idle();
    endtask : access
endmodule : host_bus_model

// ---- muxed_byte_bus_interface_bench.sv ----
// self-checking bench for the multiplexed byte bus port
`timescale 1ns/100ps
module muxed_byte_bus_interface_bench;
    logic clk_sys_i, reset_n_i, style, power_fail, host_rst_n;
    logic as_w, ds_w, rw_w, cs_n_w, host_drv_n, dev_oe_n, seen;
    logic [7:0] host_d, dev_d, bus_w, float_q, core_rdata, wr_addr, wr_data, a, d;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic [31:0] seed;
    int err_count, total_checks, wr_cnt, rd_cnt;
    muxed_bus_pkg::core_req_s req;

    assign bus_w = (dev_oe_n === 1'b0) ? dev_d : (host_drv_n === 1'b0 ? host_d : float_q);
    assign core_rdata = mem[req.addr];

    muxed_byte_bus_interface dut_u (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_lines_i(bus_w),
        .bus_lines_o(dev_d), .bus_lines_oe_n_o(dev_oe_n), .addr_latch_strobe_i(as_w),
        .data_strobe_line_i(ds_w), .dir_write_line_i(rw_w), .unit_select_n_i(cs_n_w),
        .bus_style_select_i(style), .power_fail_i(power_fail), .host_reset_n_i(host_rst_n),
        .core_req_o(req), .core_rdata_i(core_rdata));

    host_bus_model host_u (
        .clk_i(clk_sys_i), .style_i(style), .dev_oe_n_i(dev_oe_n), .dev_data_i(dev_d),
        .as_o(as_w), .ds_o(ds_w), .rw_o(rw_w), .cs_n_o(cs_n_w), .data_o(host_d),
        .drive_n_o(host_drv_n));

    // ==========================================================
    // storage core model and line monitor
    always @(posedge clk_sys_i) begin
        float_q <= ~bus_w;
        if (req.wr === 1'b1) begin
            mem[req.addr] <= req.wdata;
            wr_addr <= req.addr;
            wr_data <= req.wdata;
            wr_cnt++;
        end
        if (req.rd === 1'b1) rd_cnt++;
        if (dev_oe_n === 1'b0 && host_drv_n === 1'b0) chk(16'h0000, 16'h0001);
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : next_rand

    function automatic logic [7:0] init_val(input logic [7:0] v);
        return {v[3:0], v[7:4]} ^ 8'hA5;
    endfunction : init_val

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic do_rw(input logic [7:0] ad, input logic [7:0] dd, input logic wr,
                         input logic sel_n, input logic new_addr, input logic ok);
        int w0;
        int r0;
        logic [7:0] got;
        w0 = wr_cnt;
        r0 = rd_cnt;
        host_u.access(ad, wr, dd, sel_n, new_addr, seen, got);
        if (wr) begin
            chk(16'(wr_cnt - w0), 16'(ok));
            if (ok) chk({wr_addr, wr_data}, {ad, dd});
            if (ok) exp_mem[ad] = dd;
        end else begin
            chk(16'(seen), 16'(ok));
            chk(16'(rd_cnt - r0), 16'(ok));
            if (ok) chk(16'(got), 16'(exp_mem[ad]));
        end
        chk(16'(dev_oe_n), 16'h0001);
    endtask : do_rw

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        err_count++;
        wrap_up();
    end

    initial begin
        reset_n_i = 1'b0;
        style = 1'b0;
        power_fail = 1'b0;
        host_rst_n = 1'b1;
        float_q = 8'h00;
        seed = 32'h0000_AA31;
        for (int i = 0; i < 256; i++) mem[i] = init_val(8'(i));
        for (int i = 0; i < 256; i++) exp_mem[i] = init_val(8'(i));
        repeat (10) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        for (int m = 1; m >= 0; m--) begin
            style = m[0];
            host_u.idle();
            host_u.step(2);
            do_rw(8'hFF, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1);
            do_rw(8'h00, 8'hFF, 1'b1, 1'b0, 1'b1, 1'b1);
            do_rw(8'hFF, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
            for (int k = 0; k < 8; k++) begin
                seed = next_rand(seed);
                a = seed[7:0];
                d = seed[15:8];
                do_rw(a, d, 1'b1, 1'b0, 1'b1, 1'b1);
                do_rw(a, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
            end
            do_rw(a, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
            do_rw(~a, ~d, 1'b1, 1'b1, 1'b1, 1'b0);
            chk({8'h00, req.addr}, {8'h00, ~a});
            do_rw(a, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
            power_fail = 1'b1;
            do_rw(a, 8'h3C, 1'b1, 1'b0, 1'b1, 1'b0);
            do_rw(a, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
            power_fail = 1'b0;
            host_rst_n = 1'b0;
            do_rw(a, 8'hC3, 1'b1, 1'b0, 1'b1, 1'b0);
            do_rw(a, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
            host_rst_n = 1'b1;
            do_rw(a, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
        end
        wrap_up();
    end
endmodule : muxed_byte_bus_interface_bench
